//--- pbc_top.sv
// port b upper-nibble pin-change detector with axi4-lite registers
//
// What this block does
// - Each of pins 7 to 4 has a falling-edge enable bit that turns falling-edge detection on.
// - An enabled edge sets that pin's change flag and raises the aggregate change flag.
// - Bits 3 to 0 of the edge enable and flag registers ignore writes and read as zero.
// - A flag sets on a rising edge with its rising enable or a falling edge with its falling enable.
// - A flag stays set until software writes zero to it; zero means no enabled change since.
// - All implemented enable and flag bits reset to zero on every reset.
// - Detection and flagging go on with the master enable clear; only the request and the wake are held off.
// - The aggregate flag is the OR of all port a and port b pin flags.
// - An enabled edge arriving during a clearing write leaves its flag set, whatever was written.
// - With the master enable set an enabled edge wakes the block, flags already updated.
module pbc_top
  import pbc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // port b pins 7..4, asynchronous
  input wire logic [3:0] portb_pin_n,
  // port a flags from the sibling slice, same clock
  input wire logic [5:0] porta_change_flags,
  // aggregate flag and processor request
  output logic change_irq_aggregate_flag,
  output logic change_irq,
  // sleeping indicator, dropped on wake
  output logic sleep_state,
  // block interrupt line
  output logic irq
);

  pbc_state_s s_reg;
  pbc_state_s s_next;
  logic [3:0] pin_sync;

  // protection bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{awprot, arprot};

  // register map decode, shared by read and write paths
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      PBC_OFS_RISE_EN, PBC_OFS_FALL_EN, PBC_OFS_FLAGS, PBC_OFS_CTRL,
      PBC_OFS_STATUS, PBC_OFS_IRQ_STAT, PBC_OFS_IRQ_CLR, PBC_OFS_IRQ_EN: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // place a pin nibble at bits 7..4 of a zero word
  function automatic logic [31:0] pin_word(input logic [3:0] v);
    pin_word = {24'h000000, v, 4'h0};
  endfunction

  // pins cross into aclk before the edge logic looks at them
  pbc_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(portb_pin_n),
    .sync_out(pin_sync)
  );

  // next-state logic for the whole block
  always_comb begin
    logic [3:0] rise_hit;
    logic [3:0] fall_hit;
    logic [3:0] hit;
    logic [3:0] flags_w;
    logic [1:0] ev_set;
    logic [1:0] ev_clr;
    logic do_write;
    logic wr_ok;
    logic [7:0] wb;
    logic agg;
    logic wake;
    rise_hit = 4'h0;
    fall_hit = 4'h0;
    hit = 4'h0;
    flags_w = 4'h0;
    ev_set = 2'h0;
    ev_clr = 2'h0;
    do_write = 1'b0;
    wr_ok = 1'b0;
    wb = 8'h00;
    agg = 1'b0;
    wake = 1'b0;
    s_next = s_reg;

    // edge detection every cycle against the previous sample
    s_next.pin_prev = pin_sync;
    rise_hit = pin_sync & ~s_reg.pin_prev & s_reg.rise_en;
    fall_hit = ~pin_sync & s_reg.pin_prev & s_reg.fall_en;
    // no gating by the master enable: flags move regardless
    hit = rise_hit | fall_hit;

    // write address channel: accept once, hold until response done
    if (awvalid && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = awaddr;
      s_next.awready = 1'b0;
    end
    // write data channel, independent of address order
    if (wvalid && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.w_byte = wdata[7:0];
      s_next.w_lane0 = wstrb[0];
      s_next.wready = 1'b0;
    end

    case (s_reg.wr_phase)
      PBC_WR_IDLE: begin
        if (s_reg.aw_got && s_reg.w_got) begin
          do_write = 1'b1;
          wr_ok = addr_mapped(s_reg.aw_addr);
          s_next.bvalid = 1'b1;
          s_next.bresp = wr_ok ? PBC_RESP_OKAY : PBC_RESP_SLVERR;
          s_next.wr_phase = PBC_WR_RESP;
        end
      end
      PBC_WR_RESP: begin
        // reopen both channels only after the response is taken
        if (bready) begin
          s_next.bvalid = 1'b0;
          s_next.aw_got = 1'b0;
          s_next.w_got = 1'b0;
          s_next.awready = 1'b1;
          s_next.wready = 1'b1;
          s_next.wr_phase = PBC_WR_IDLE;
        end
      end
      default: begin
        s_next.wr_phase = PBC_WR_IDLE;
      end
    endcase

    // register writes; registers are eight bits so only lane 0 matters
    wb = s_reg.w_byte;
    flags_w = s_reg.flags;
    if (do_write && wr_ok && s_reg.w_lane0) begin
      case (s_reg.aw_addr)
        PBC_OFS_RISE_EN: s_next.rise_en = wb[PBC_PIN_HI:PBC_PIN_LO];
        PBC_OFS_FALL_EN: s_next.fall_en = wb[PBC_PIN_HI:PBC_PIN_LO];
        // writing zero clears, writing one leaves the flag as is
        PBC_OFS_FLAGS: flags_w = s_reg.flags & wb[PBC_PIN_HI:PBC_PIN_LO];
        PBC_OFS_CTRL: s_next.ctrl = wb[1:0];
        PBC_OFS_IRQ_CLR: ev_clr = wb[1:0];
        PBC_OFS_IRQ_EN: s_next.ev_en = wb[1:0];
        default: begin
          flags_w = s_reg.flags;
        end
      endcase
    end

    // hardware set wins over a concurrent clear
    s_next.flags = flags_w | hit;

    // aggregate over both ports, built from the next flag value
    agg = (|s_next.flags) | (|porta_change_flags);
    s_next.agg_flag = agg;
    // request to the processor only when the master enable is set
    s_next.change_irq = agg & s_reg.ctrl[PBC_CTRL_MIE];

    // wake: flags are updated in the same edge that drops sleep
    wake = (|hit) & s_reg.ctrl[PBC_CTRL_MIE] & s_reg.ctrl[PBC_CTRL_SLEEP];
    if (wake) begin
      s_next.ctrl[PBC_CTRL_SLEEP] = 1'b0;
    end

    // sticky block events, set beats clear
    ev_set[PBC_EV_CHANGE] = |hit;
    ev_set[PBC_EV_WAKE] = wake;
    s_next.ev_stat = (s_reg.ev_stat & ~ev_clr) | ev_set;
    s_next.irq = |(s_next.ev_stat & s_next.ev_en);

    // read channel: one outstanding read, data registered
    if (arvalid && s_reg.arready) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = addr_mapped(araddr) ? PBC_RESP_OKAY : PBC_RESP_SLVERR;
      case (araddr)
        PBC_OFS_RISE_EN: s_next.rdata = pin_word(s_reg.rise_en);
        PBC_OFS_FALL_EN: s_next.rdata = pin_word(s_reg.fall_en);
        PBC_OFS_FLAGS: s_next.rdata = pin_word(s_reg.flags);
        PBC_OFS_CTRL: s_next.rdata = {30'h00000000, s_reg.ctrl};
        PBC_OFS_STATUS: s_next.rdata = {29'h00000000, |s_reg.flags,
                                        |porta_change_flags, s_reg.agg_flag};
        PBC_OFS_IRQ_STAT: s_next.rdata = {30'h00000000, s_reg.ev_stat};
        PBC_OFS_IRQ_EN: s_next.rdata = {30'h00000000, s_reg.ev_en};
        // clear register is write-only and reads zero
        default: s_next.rdata = 32'h00000000;
      endcase
    end else if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
  end

  // single state register; reset zeroes all enables and flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
      s_reg.rise_en <= PBC_RST_PINS;
      s_reg.fall_en <= PBC_RST_PINS;
      s_reg.flags <= PBC_RST_PINS;
      s_reg.ctrl <= PBC_RST_CTRL;
      s_reg.ev_stat <= PBC_RST_EV;
      s_reg.ev_en <= PBC_RST_EV;
      s_reg.wr_phase <= PBC_WR_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign change_irq_aggregate_flag = s_reg.agg_flag;
  assign change_irq = s_reg.change_irq;
  assign sleep_state = s_reg.ctrl[PBC_CTRL_SLEEP];
  assign irq = s_reg.irq;

endmodule

//--- pbc_pkg.sv
// shared constants and carrier types of the port b pin-change block
package pbc_pkg;

  // register byte offsets
  localparam logic [7:0] PBC_OFS_RISE_EN = 8'h00;
  localparam logic [7:0] PBC_OFS_FALL_EN = 8'h04;
  localparam logic [7:0] PBC_OFS_FLAGS = 8'h08;
  localparam logic [7:0] PBC_OFS_CTRL = 8'h0c;
  localparam logic [7:0] PBC_OFS_STATUS = 8'h10;
  localparam logic [7:0] PBC_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] PBC_OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] PBC_OFS_IRQ_EN = 8'h1c;

  // field layout: pins live in bits 7..4 of the edge and flag registers
  localparam int PBC_PIN_LO = 4;
  localparam int PBC_PIN_HI = 7;
  localparam int PBC_NPIN = 4;
  localparam int PBC_PORTA_W = 6;

  // control register fields
  localparam int PBC_CTRL_MIE = 0;
  localparam int PBC_CTRL_SLEEP = 1;

  // status register fields
  localparam int PBC_ST_AGG = 0;
  localparam int PBC_ST_PORTA = 1;
  localparam int PBC_ST_PORTB = 2;

  // block interrupt event bits
  localparam int PBC_EV_CHANGE = 0;
  localparam int PBC_EV_WAKE = 1;
  localparam int PBC_NEV = 2;

  // reset values
  localparam logic [3:0] PBC_RST_PINS = 4'h0;
  localparam logic [1:0] PBC_RST_CTRL = 2'h0;
  localparam logic [1:0] PBC_RST_EV = 2'h0;

  // axi response codes
  localparam logic [1:0] PBC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PBC_RESP_SLVERR = 2'h2;

  // synchroniser depth in flip-flops
  localparam int PBC_SYNC_STAGES = 2;

  // write channel phases
  typedef enum logic [1:0] {
    PBC_WR_IDLE = 2'b00,
    PBC_WR_RESP = 2'b01
  } pbc_wr_e;

  // two-flop synchroniser state for the pin group
  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
  } pbc_sync_s;

  // all state of the top module
  typedef struct packed {
    pbc_wr_e wr_phase;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] pin_prev;
    logic [3:0] rise_en;
    logic [3:0] fall_en;
    logic [3:0] flags;
    logic [1:0] ctrl;
    logic agg_flag;
    logic change_irq;
    logic [1:0] ev_stat;
    logic [1:0] ev_en;
    logic irq;
  } pbc_state_s;

endpackage

//--- pbc_sync.sv
// two flip-flop synchroniser for the port b pin inputs
module pbc_sync
  import pbc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] async_in,
  output logic [3:0] sync_out
);

  pbc_sync_s st_reg;
  pbc_sync_s st_next;

  // first stage feeds only the second stage, never any logic
  always_comb begin
    st_next = st_reg;
    st_next.meta = async_in;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.sync;

endmodule

//--- pbc_assertions.sv
// concurrent checks on the pin-change block ports
module pbc_assertions
  import pbc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [5:0] porta_change_flags,
  input wire logic change_irq_aggregate_flag,
  input wire logic change_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  rst_idle_a: assert property ($rose(aresetn) |-> !change_irq_aggregate_flag && !bvalid)
    else $error("outputs not idle after reset");
  agg_porta_a: assert property (|porta_change_flags |=> change_irq_aggregate_flag)
    else $error("aggregate flag missed a port a flag");
  agg_fall_a: assert property ($fell(change_irq_aggregate_flag) |-> $past(porta_change_flags) == 6'h0)
    else $error("aggregate flag dropped with port a flag set");
  irq_gate_a: assert property (change_irq |-> change_irq_aggregate_flag)
    else $error("request without aggregate flag");
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  busy_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
endmodule

bind pbc_top pbc_assertions chk (.*);

//--- pbc_pins_model.sv
// external pins and port a slice driving the block
module pbc_pins_model (
  input wire logic aclk,
  input wire logic [3:0] pin_set,
  input wire logic [5:0] pa_set,
  output logic [3:0] portb_pin_n,
  output logic [5:0] porta_change_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins move off the clock edge, since they are asynchronous to the block
  always @(posedge aclk) begin
    portb_pin_n <= #7 pin_set;
    porta_change_flags <= pa_set;
  end
endmodule

//--- pbc_tb_top.sv
// self-checking bench for the port b pin-change block
module pbc_tb_top
  import pbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d, r;
  logic awready, wready, bvalid, arready, rvalid, agg, cirq, slp_o, irq;
  logic [1:0] bresp, rresp, rs, bs;
  logic bready = 0, rready = 0;
  logic [3:0] strb = 4'hf;
  logic [3:0] pins, pin_set = 0, en_r, en_f, nw, old = 0, ex;
  logic [5:0] pa, pa_set = 0;
  logic mie, slp, hit;
  int mismatches = 0, n_compared = 0;
  // cycles that bready and rready lag behind a request, so the hold checks see stalls
  int lag = 0;

  always #10 aclk = ~aclk;

  pbc_pins_model pm (.aclk(aclk), .pin_set(pin_set), .pa_set(pa_set), .portb_pin_n(pins),
    .porta_change_flags(pa));
  // response readies are driven by the bus tasks, sometimes a few cycles late
  pbc_top uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(strb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .portb_pin_n(pins), .porta_change_flags(pa),
    .change_irq_aggregate_flag(agg), .change_irq(cirq), .sleep_state(slp_o), .irq(irq));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bs = bresp;
        return;
      end
      if (i + 1 >= lag) bready <= 1'b1;
    end
    mismatches++;
    finish_test();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        v = rdata;
        rr = rresp;
        return;
      end
      if (i + 1 >= lag) rready <= 1'b1;
    end
    mismatches++;
    finish_test();
  endtask

  // reset, reset values, an unmapped read, then random edge rounds
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      rd(8'(i * 4), d, rs);
      chk("reset value", 32'h0, d);
    end
    rd(8'h20, d, rs);
    chk("unmapped resp", {30'h0, PBC_RESP_SLVERR}, {30'h0, rs});
    chk("unmapped data", 32'h0, d);
    wr(8'h24, 32'hff);
    chk("unmapped write", {30'h0, PBC_RESP_SLVERR}, {30'h0, bs});
    r = 32'he3fc;
    for (int k = 0; k < 40; k++) begin
      r = xs(r);
      lag = int'(r[25:24]);
      {nw, en_f, en_r} = r[11:0];
      {slp, mie} = r[13:12];
      pa_set <= (r[15:14] == 2'h0) ? r[21:16] : 6'h0;
      wr(PBC_OFS_RISE_EN, {24'h0, en_r, 4'h5});
      wr(PBC_OFS_FALL_EN, {24'h0, en_f, 4'ha});
      wr(PBC_OFS_CTRL, {30'h0, slp, mie});
      chk("write resp", {30'h0, PBC_RESP_OKAY}, {30'h0, bs});
      wr(PBC_OFS_IRQ_EN, {30'h0, r[23:22]});
      wr(PBC_OFS_FLAGS, 32'h0);
      wr(PBC_OFS_IRQ_CLR, 32'h3);
      rd(PBC_OFS_FLAGS, d, rs);
      chk("cleared flags", 32'h0, d);
      chk("irq after clear", 32'h0, {31'h0, irq});
      pin_set <= nw;
      repeat (8) @(posedge aclk);
      ex = (en_r & ~old & nw) | (en_f & old & ~nw);
      hit = |ex;
      rd(PBC_OFS_FLAGS, d, rs);
      chk("flags", {24'h0, ex, 4'h0}, d);
      chk("read resp", {30'h0, PBC_RESP_OKAY}, {30'h0, rs});
      rd(PBC_OFS_STATUS, d, rs);
      chk("status", {29'h0, hit, |pa_set, hit | (|pa_set)}, d);
      rd(PBC_OFS_IRQ_STAT, d, rs);
      chk("event status", {30'h0, slp & mie & hit, hit}, d);
      chk("sleep", {31'h0, slp & ~(mie & hit)}, {31'h0, slp_o});
      rd(PBC_OFS_RISE_EN, d, rs);
      chk("rise enable", {24'h0, en_r, 4'h0}, d);
      rd(PBC_OFS_FALL_EN, d, rs);
      chk("fall enable", {24'h0, en_f, 4'h0}, d);
      rd(PBC_OFS_CTRL, d, rs);
      chk("ctrl", {30'h0, slp & ~(mie & hit), mie}, d);
      chk("aggregate", {31'h0, hit | (|pa_set)}, {31'h0, agg});
      chk("request", {31'h0, (hit | (|pa_set)) & mie}, {31'h0, cirq});
      chk("irq", {31'h0, (hit & r[22]) | (slp & mie & hit & r[23])}, {31'h0, irq});
      old = nw;
    end
    // edges timed to land in the very cycle of a clearing write keep their flags
    wr(PBC_OFS_RISE_EN, 32'hf0);
    wr(PBC_OFS_FALL_EN, 32'hf0);
    pin_set <= ~old;
    repeat (2) @(posedge aclk);
    wr(PBC_OFS_FLAGS, 32'h0);
    rd(PBC_OFS_FLAGS, d, rs);
    chk("edge during clear", 32'hf0, d);
    // a write without lane 0 must leave the register alone
    strb <= 4'he;
    wr(PBC_OFS_RISE_EN, 32'h0);
    strb <= 4'hf;
    rd(PBC_OFS_RISE_EN, d, rs);
    chk("masked write", 32'hf0, d);
    // a second reset from a busy state clears enables and flags again
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      rd(8'(i * 4), d, rs);
      chk("value after reset", 32'h0, d);
    end
    finish_test();
  end
endmodule
